/* File: fspc_pkg.sv */
package fspc_pkg;
  localparam logic [7:0] OP_WRITE_ENABLE_COMMAND    = 8'h06;
  localparam logic [7:0] OP_WRDI    = 8'h04;
  localparam logic [7:0] OP_RDSR_LO = 8'h05;
  localparam logic [7:0] OP_RDSR_HI = 8'h35;
  localparam logic [7:0] OP_RDCR_A  = 8'h15;
  localparam logic [7:0] OP_RDCR_B  = 8'h45;
  localparam logic [7:0] OP_WRSR    = 8'h01;
  localparam logic [7:0] OP_WRSR_HI = 8'h31;
  localparam logic [7:0] OP_WRCR    = 8'h11;
  localparam logic [7:0] OP_PROG    = 8'h02;
  localparam logic [7:0] OP_SEC_PRG = 8'h42;
  localparam logic [7:0] OP_PERASE  = 8'h81;
  localparam logic [7:0] OP_SERASE  = 8'h20;
  localparam logic [7:0] OP_HERASE  = 8'h52;
  localparam logic [7:0] OP_BERASE  = 8'hD8;
  localparam logic [7:0] OP_CERASE  = 8'h60;
  localparam logic [7:0] OP_CERASE2 = 8'hC7;
  localparam logic [7:0] OP_SUSP_A  = 8'h75;
  localparam logic [7:0] OP_SUSP_B  = 8'hB0;
  localparam logic [7:0] OP_RES_A   = 8'h7A;
  localparam logic [7:0] OP_RES_B   = 8'h30;
  localparam logic [7:0] OP_RST_EN  = 8'h66;
  localparam logic [7:0] OP_RST_GO  = 8'h99;
  localparam logic [7:0] OP_DPD_IN  = 8'hAB;
  localparam logic [7:0] OP_DPD_OUT = 8'hB9;
  localparam logic [1:0] SRP_SW     = 2'b00;
  localparam logic [1:0] SRP_HW     = 2'b01;
  localparam logic [1:0] SRP_LOCK   = 2'b10;
  localparam logic [1:0] DRV_RESET  = 2'b11;
  localparam logic [4:0] SYNC_RESET = 5'h0B;
  localparam logic [10:0] SEC_TOTAL = 11'h400;
  localparam logic [10:0] SPAN_HALF = 11'h008;
  localparam logic [10:0] SPAN_BLK  = 11'h010;
  localparam logic [10:0] BYTE_MAX  = 11'h7FF;
  localparam logic [9:0]  SEC_LAST  = 10'h3FF;
  localparam logic [23:0] PAGE_NARROW = 24'hFF_FF00;
  localparam logic [23:0] PAGE_WIDE   = 24'hFF_FC00;
  localparam logic [3:0] DUAL_SHORT = 4'h4;
  localparam logic [3:0] DUAL_LONG  = 4'h8;
  localparam logic [3:0] QUAD_SHORT = 4'h6;
  localparam logic [3:0] QUAD_LONG  = 4'hA;
  localparam logic [6:0] PCT_00 = 7'h50;
  localparam logic [6:0] PCT_01 = 7'h28;
  localparam logic [6:0] PCT_10 = 7'h64;
  localparam logic [6:0] PCT_11 = 7'h3C;
  typedef enum logic [1:0] {
    MODE_STANDBY = 2'b00,
    MODE_ACTIVE  = 2'b01,
    MODE_DPD     = 2'b10
  } fspc_mode_type;
  typedef struct packed {
    logic erase_suspended_flag;
    logic protect_complement;
    logic [2:0] lock;
    logic program_suspended_flag;
    logic quad_enable;
    logic [1:0] srp;
    logic [4:0] bp;
    logic write_enable_latch;
    logic busy;
  } fspc_status_type;
  typedef struct packed {
    logic rsv7;
    logic [1:0] drv;
    logic wide_page_select;
    logic [2:0] rsv3;
    logic dummy_length_select;
  } fspc_cfg_type;
  typedef struct packed {
    logic [1:0] srp;
    logic quad_enable;
    logic [2:0] lock;
    logic protect_complement;
    logic [4:0] bp;
    logic [1:0] drv;
    logic dummy_length_select;
  } fspc_nv_type;
  typedef struct packed {
    logic [7:0] op;
    logic [23:0] addr;
    logic wide;
  } fspc_pe_type;
  typedef struct packed {
    logic [7:0] data;
    logic [9:0] addr;
  } fspc_pgm_type;
  typedef struct packed {
    logic quad_mode;
    logic wp_active;
    logic pause_active;
    logic [6:0] drive_pct;
    logic [3:0] dual_dummy;
    logic [3:0] quad_dummy;
    logic wide;
  } fspc_view_type;
  typedef struct packed {
    logic en;
    logic [9:0] lo;
    logic [9:0] hi;
  } fspc_prot_type;
endpackage

/* File: fspc_top.sv */
`timescale 1ns/1ps
module fspc_top
  import fspc_pkg::*;
(
  input  wire logic    clock_i,
  input  wire logic    reset_n_i,
  input  wire logic    spi_sclk_i,
  input  wire logic    spi_cs_n_i,
  input  wire logic    io0_i,
  input  wire logic    wp_n_io2_i,
  input  wire logic    hold_n_io3_i,
  input  wire logic    erase_busy_i,
  input  wire logic    program_busy_i,
  input  fspc_nv_type  nv_load_i,
  output logic         so_o,
  output logic         so_oe_o,
  output logic [15:0]  status_word_o,
  output logic [7:0]   configuration_word_o,
  output logic         pe_req_o,
  output fspc_pe_type  pe_cmd_o,
  output logic         pgm_valid_o,
  output fspc_pgm_type pgm_byte_o,
  output fspc_view_type view_o,
  output fspc_nv_type  nv_store_o
);
  logic [4:0] meta_reg, sync_reg, prev_reg;
  logic [7:0] shift_reg, op_reg, lo_reg, hi_reg, tx_reg;
  logic [2:0] bit_cnt_reg, lock_reg;
  logic [10:0] byte_cnt_reg, span, t_lo, t_hi;
  logic [23:0] addr_reg;
  logic [1:0] srp_reg, drv_reg;
  logic [4:0] bp_reg;
  logic [9:0] ptr_reg;
  logic boot_reg, qe_reg, cmp_reg, wide_reg, dc_reg, wel_reg;
  logic sus_e_reg, sus_p_reg, arm_reg, rd_reg, so_reg, so_oe_reg;
  logic pe_req_reg, pgm_valid_reg;
  fspc_mode_type mode_reg;
  fspc_pe_type pe_reg;
  fspc_pgm_type pgm_reg;
  fspc_view_type view_reg;
  logic [15:0] status_reg;
  logic [7:0] cfg_reg;
  fspc_nv_type nv_reg;
  // the first stage is read only by sync_reg
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      meta_reg <= SYNC_RESET;
      sync_reg <= SYNC_RESET;
      prev_reg <= SYNC_RESET;
    end else begin
      meta_reg <= {spi_sclk_i, spi_cs_n_i, io0_i, wp_n_io2_i, hold_n_io3_i};
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end
  logic sclk_s, cs_s, io_s, wp_s, hold_s, paused, hw_lock, wip;
  logic cs_rise, cs_fall, sck_rise, sck_fall, byte_end, aligned;
  logic fin, go, ok, pe_shape, hit, sec_block, pe_ok, wsr, wcr;
  logic [7:0] bval, hb;
  fspc_status_type st, w;
  fspc_cfg_type cw;
  fspc_prot_type pr;
  assign sclk_s = sync_reg[4];
  assign cs_s = sync_reg[3];
  assign io_s = sync_reg[2];
  assign wp_s = sync_reg[1];
  assign hold_s = sync_reg[0];
  assign paused = !hold_s && !qe_reg;
  assign cs_rise = cs_s && !prev_reg[3];
  assign cs_fall = !cs_s && prev_reg[3];
  assign sck_rise = sclk_s && !prev_reg[4] && !cs_s && !paused;
  assign sck_fall = !sclk_s && prev_reg[4] && !cs_s && !paused;
  assign bval = {shift_reg[6:0], io_s};
  assign byte_end = sck_rise && bit_cnt_reg == 3'd7;
  assign aligned = bit_cnt_reg == 3'd0;
  assign wip = erase_busy_i || program_busy_i;
  assign fin = cs_rise && aligned && !boot_reg;
  assign go = fin && mode_reg != MODE_DPD;
  assign ok = go && wel_reg && !wip;
  // WP only guards while the pin still has its own function
  assign hw_lock = srp_reg == SRP_HW && !wp_s && !qe_reg;
  assign st = {sus_e_reg, cmp_reg, lock_reg, sus_p_reg, qe_reg, srp_reg,
               bp_reg, wel_reg, wip};
  assign hb = (op_reg == OP_WRSR_HI) ? lo_reg : hi_reg;
  assign w = fspc_status_type'({hb, lo_reg});
  assign cw = fspc_cfg_type'(lo_reg);
  assign wsr = ok && ((op_reg == OP_WRSR && (byte_cnt_reg == 11'd2 ||
               byte_cnt_reg == 11'd3)) ||
               (op_reg == OP_WRSR_HI && byte_cnt_reg == 11'd2));
  assign wcr = ok && op_reg == OP_WRCR && byte_cnt_reg == 11'd2;

  function automatic fspc_prot_type prot_map(input logic [4:0] bp,
                                             input logic cmp);
    logic [10:0] sz;
    logic up;
    fspc_prot_type r;
    up = !bp[3];
    if (bp[2:0] == 3'd7)
      sz = SEC_TOTAL;
    else if (bp[2:0] == 3'd0)
      sz = 11'd0;
    else if (!bp[4])
      sz = SPAN_BLK << (bp[2:0] - 3'd1);
    else if (bp[2])
      sz = SPAN_HALF;
    else
      sz = 11'd1 << (bp[1:0] - 2'd1);
    if (cmp) begin
      sz = SEC_TOTAL - sz;
      up = !up;
    end
    r.en = sz != 11'd0;
    r.lo = up ? 10'(SEC_TOTAL - sz) : 10'd0;
    r.hi = up ? SEC_LAST : 10'(sz - 11'd1);
    return r;
  endfunction

  always_comb begin
    case (op_reg)
      OP_HERASE: span = SPAN_HALF;
      OP_BERASE: span = SPAN_BLK;
      OP_CERASE, OP_CERASE2: span = SEC_TOTAL;
      default: span = 11'd1;
    endcase
    t_lo = {1'b0, addr_reg[21:12]} & ~(span - 11'd1);
    t_hi = t_lo + span - 11'd1;
    pr = prot_map(bp_reg, cmp_reg);
    // chip erase spans everything, so any protection blocks it
    hit = pr.en && op_reg != OP_SEC_PRG && !(t_hi < {1'b0, pr.lo} ||
          t_lo > {1'b0, pr.hi});
    sec_block = op_reg == OP_SEC_PRG && (addr_reg[13:12] == 2'd0 ||
                lock_reg[addr_reg[13:12] - 2'd1]);
    case (op_reg)
      OP_PROG, OP_SEC_PRG: pe_shape = byte_cnt_reg >= 11'd5;
      OP_PERASE, OP_SERASE, OP_HERASE, OP_BERASE:
        pe_shape = byte_cnt_reg == 11'd4;
      OP_CERASE, OP_CERASE2: pe_shape = byte_cnt_reg == 11'd1;
      default: pe_shape = 1'b0;
    endcase
    pe_ok = ok && pe_shape && !hit && !sec_block;
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      shift_reg <= 8'h00;
      bit_cnt_reg <= 3'd0;
      byte_cnt_reg <= 11'd0;
      op_reg <= 8'h00;
      addr_reg <= 24'h00_0000;
      lo_reg <= 8'h00;
      hi_reg <= 8'h00;
    end else if (cs_fall) begin
      bit_cnt_reg <= 3'd0;
      byte_cnt_reg <= 11'd0;
    end else if (sck_rise) begin
      shift_reg <= bval;
      bit_cnt_reg <= bit_cnt_reg + 3'd1;
      if (byte_end) begin
        if (byte_cnt_reg != BYTE_MAX)
          byte_cnt_reg <= byte_cnt_reg + 11'd1;
        if (byte_cnt_reg == 11'd0)
          op_reg <= bval;
        else if (byte_cnt_reg <= 11'd3)
          addr_reg <= {addr_reg[15:0], bval};
        if (byte_cnt_reg == 11'd1)
          lo_reg <= bval;
        if (byte_cnt_reg == 11'd2)
          hi_reg <= bval;
      end
    end
  end

  // non-volatile image arrives from outside one cycle after reset
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      boot_reg <= 1'b1;
      srp_reg <= SRP_SW;
      qe_reg <= 1'b0;
      lock_reg <= 3'b000;
      cmp_reg <= 1'b0;
      bp_reg <= 5'b00000;
    end else if (boot_reg) begin
      boot_reg <= 1'b0;
      srp_reg <= (nv_load_i.srp == SRP_LOCK) ? SRP_SW : nv_load_i.srp;
      qe_reg <= nv_load_i.quad_enable;
      lock_reg <= nv_load_i.lock;
      cmp_reg <= nv_load_i.protect_complement;
      bp_reg <= nv_load_i.bp;
    end else if (wsr && !srp_reg[1]) begin
      if (op_reg == OP_WRSR && !hw_lock) begin
        srp_reg[0] <= w.srp[0];
        bp_reg <= w.bp;
      end
      if (op_reg == OP_WRSR_HI || byte_cnt_reg == 11'd3) begin
        qe_reg <= w.quad_enable;
        lock_reg <= lock_reg | w.lock;
        if (!hw_lock) begin
          srp_reg[1] <= w.srp[1];
          cmp_reg <= w.protect_complement;
        end
      end
    end
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      drv_reg <= DRV_RESET;
      wide_reg <= 1'b0;
      dc_reg <= 1'b0;
    end else if (boot_reg) begin
      drv_reg <= nv_load_i.drv;
      dc_reg <= nv_load_i.dummy_length_select;
    end else if (wcr) begin
      drv_reg <= cw.drv;
      wide_reg <= cw.wide_page_select;
      dc_reg <= cw.dummy_length_select;
    end
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wel_reg <= 1'b0;
      arm_reg <= 1'b0;
    end else if (go) begin
      arm_reg <= byte_cnt_reg == 11'd1 && op_reg == OP_RST_EN;
      if (byte_cnt_reg == 11'd1 && op_reg == OP_WRITE_ENABLE_COMMAND)
        wel_reg <= 1'b1;
      else if ((byte_cnt_reg == 11'd1 && op_reg == OP_WRDI) || wsr ||
               wcr || pe_ok || (arm_reg && op_reg == OP_RST_GO))
        wel_reg <= 1'b0;
    end
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sus_e_reg <= 1'b0;
      sus_p_reg <= 1'b0;
    end else if (go && byte_cnt_reg == 11'd1) begin
      if (op_reg == OP_SUSP_A || op_reg == OP_SUSP_B) begin
        if (erase_busy_i)
          sus_e_reg <= 1'b1;
        else if (program_busy_i)
          sus_p_reg <= 1'b1;
      end else if (op_reg == OP_RES_A || op_reg == OP_RES_B ||
                   (arm_reg && op_reg == OP_RST_GO)) begin
        sus_e_reg <= 1'b0;
        sus_p_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i)
      mode_reg <= MODE_STANDBY;
    else if (boot_reg)
      mode_reg <= MODE_STANDBY;
    else if (mode_reg == MODE_DPD) begin
      if (fin && byte_cnt_reg == 11'd1 && op_reg == OP_DPD_OUT)
        mode_reg <= MODE_STANDBY;
    end else if (go && byte_cnt_reg == 11'd1 && op_reg == OP_DPD_IN)
      mode_reg <= MODE_DPD;
    else if (cs_rise)
      mode_reg <= MODE_STANDBY;
    else if (cs_fall)
      mode_reg <= MODE_ACTIVE;
  end

  function automatic logic [7:0] rd_sel(input logic [7:0] op,
                                        input fspc_status_type s,
                                        input logic [7:0] c);
    case (op)
      OP_RDSR_LO: return s[7:0];
      OP_RDSR_HI: return s[15:8];
      default: return c;
    endcase
  endfunction

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rd_reg <= 1'b0;
      tx_reg <= 8'h00;
      so_reg <= 1'b0;
      so_oe_reg <= 1'b0;
    end else begin
      so_oe_reg <= rd_reg && !cs_s && !paused;
      if (cs_rise || cs_fall)
        rd_reg <= 1'b0;
      else if (byte_end && byte_cnt_reg == 11'd0 &&
               mode_reg != MODE_DPD && (bval == OP_RDSR_LO ||
               bval == OP_RDSR_HI || bval == OP_RDCR_A ||
               bval == OP_RDCR_B)) begin
        rd_reg <= 1'b1;
        tx_reg <= rd_sel(bval, st, cfg_reg);
      end else if (byte_end && rd_reg)
        tx_reg <= rd_sel(op_reg, st, cfg_reg);
      else if (sck_fall && rd_reg) begin
        so_reg <= tx_reg[7];
        tx_reg <= {tx_reg[6:0], 1'b0};
      end
    end
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ptr_reg <= 10'd0;
      pgm_valid_reg <= 1'b0;
      pgm_reg <= '0;
    end else begin
      pgm_valid_reg <= 1'b0;
      if (byte_end && op_reg == OP_PROG) begin
        if (byte_cnt_reg == 11'd3)
          ptr_reg <= {addr_reg[1:0], bval};
        else if (byte_cnt_reg >= 11'd4 && wel_reg &&
                 mode_reg != MODE_DPD) begin
          pgm_valid_reg <= 1'b1;
          pgm_reg <= {bval, ptr_reg};
          // narrow page keeps bits 9:8 so the load wraps in 256 bytes
          ptr_reg <= wide_reg ? ptr_reg + 10'd1 :
                     {ptr_reg[9:8], ptr_reg[7:0] + 8'd1};
        end
      end
    end
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pe_req_reg <= 1'b0;
      pe_reg <= '0;
    end else begin
      pe_req_reg <= pe_ok;
      if (pe_ok) begin
        pe_reg.op <= op_reg;
        pe_reg.wide <= wide_reg;
        if (op_reg == OP_PERASE)
          pe_reg.addr <= addr_reg & (wide_reg ? PAGE_WIDE :
                         PAGE_NARROW);
        else
          pe_reg.addr <= addr_reg;
      end
    end
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      view_reg <= '0;
      status_reg <= 16'h0000;
      cfg_reg <= 8'h00;
      nv_reg <= '0;
    end else begin
      view_reg.quad_mode <= qe_reg;
      view_reg.wp_active <= !qe_reg;
      view_reg.pause_active <= paused;
      case (drv_reg)
        2'b00: view_reg.drive_pct <= PCT_00;
        2'b01: view_reg.drive_pct <= PCT_01;
        2'b10: view_reg.drive_pct <= PCT_10;
        default: view_reg.drive_pct <= PCT_11;
      endcase
      view_reg.dual_dummy <= dc_reg ? DUAL_LONG : DUAL_SHORT;
      view_reg.quad_dummy <= dc_reg ? QUAD_LONG : QUAD_SHORT;
      view_reg.wide <= wide_reg;
      status_reg <= st;
      cfg_reg <= {1'b0, drv_reg, wide_reg, 3'b000, dc_reg};
      nv_reg <= {srp_reg, qe_reg, lock_reg, cmp_reg, bp_reg, drv_reg,
                 dc_reg};
    end
  end

  assign so_o = so_reg;
  assign so_oe_o = so_oe_reg;
  assign status_word_o = status_reg;
  assign configuration_word_o = cfg_reg;
  assign pe_req_o = pe_req_reg;
  assign pe_cmd_o = pe_reg;
  assign pgm_valid_o = pgm_valid_reg;
  assign pgm_byte_o = pgm_reg;
  assign view_o = view_reg;
  assign nv_store_o = nv_reg;

  sequence s_resume;
    go && byte_cnt_reg == 11'd1 && (op_reg == OP_RES_A || op_reg == OP_RES_B);
  endsequence
  sequence s_dc_long;
    dc_reg ##1 dc_reg;
  endsequence
  chk_sus_clear: assert property (
    @(posedge clock_i) disable iff (!reset_n_i)
    s_resume |=> !sus_e_reg && !sus_p_reg) else $error("suspend kept");
  chk_dummy_long: assert property (
    @(posedge clock_i) disable iff (!reset_n_i)
    s_dc_long |=> view_reg.dual_dummy == 4'h8 &&
    view_reg.quad_dummy == 4'hA) else $error("dummy count wrong");
  chk_lock_sticky: assert property (
    @(posedge clock_i) disable iff (!reset_n_i)
    !boot_reg |=> (lock_reg & $past(lock_reg)) == $past(lock_reg))
    else $error("lock bit cleared");
  chk_wel_gate: assert property (
    @(posedge clock_i) disable iff (!reset_n_i)
    pe_req_reg |-> $past(wel_reg) && !wel_reg) else $error("wel bypass");
  chk_prot_hit: assert property (
    @(posedge clock_i) disable iff (!reset_n_i)
    pe_req_reg |-> !$past(hit)) else $error("protected target run");
  chk_dpd_quiet: assert property (
    @(posedge clock_i) disable iff (!reset_n_i)
    pe_req_reg |-> $past(mode_reg) != MODE_DPD) else $error("dpd command");
  chk_byte_edge: assert property (
    @(posedge clock_i) disable iff (!reset_n_i)
    pe_req_reg |-> $past(aligned)) else $error("partial byte run");
  chk_hw_hold: assert property (
    @(posedge clock_i) disable iff (!reset_n_i)
    hw_lock && !boot_reg |=> $stable({cmp_reg, bp_reg, srp_reg}))
    else $error("hw protect broken");
  chk_boot_srp: assert property (
    @(posedge clock_i) disable iff (!reset_n_i)
    boot_reg |=> srp_reg != 2'b10) else $error("lock-down survived");
endmodule

/* File: fspc_host_model.sv */
`timescale 1ns/1ps
module fspc_host_model (
  input  wire logic clock_i,
  output logic      sclk_o,
  output logic      cs_n_o,
  output logic      si_o
);
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    si_o   = 1'b0;
  end
  // mode 0: clock idles low and runs only inside a frame; si flips after
  // the frame so the device cannot lean on a stale level
  task automatic frame(input logic [63:0] d, input int n);
    @(posedge clock_i);
    cs_n_o <= 1'b0;
    for (int i = 0; i < n; i++) begin
      si_o <= d[63-i];
      repeat (4) @(posedge clock_i);
      sclk_o <= 1'b1;
      repeat (4) @(posedge clock_i);
      sclk_o <= 1'b0;
    end
    repeat (4) @(posedge clock_i);
    cs_n_o <= 1'b1; // clock count is exactly n, chosen by caller
    si_o   <= ~si_o;
    repeat (10) @(posedge clock_i);
  endtask
endmodule

/* File: fspc_tb_top.sv */
`timescale 1ns/1ps
module fspc_tb_top
  import fspc_pkg::*;
  ;
  typedef struct {
    logic [31:0] d;
    int          n;
    logic [1:0]  busy;
    logic        wp;
    logic [23:0] mask;
    logic [23:0] exp;
    int          pe;
  } fspc_row_type;
  logic          clock_i;
  logic          reset_n_i;
  logic          erase_busy;
  logic          program_busy;
  logic          wp_n;
  logic          sclk;
  logic          cs_n;
  logic          si;
  logic          hold_n;
  logic          so;
  logic          so_oe;
  logic [7:0]    rx;
  logic [23:0]   regs;
  fspc_nv_type   nv;
  logic [15:0]   status_word_o;
  logic [7:0]    configuration_word_o;
  logic          pe_req_o;
  fspc_pe_type   pe_cmd_o;
  logic          pgm_valid_o;
  fspc_pgm_type  pgm_byte_o;
  fspc_view_type view_o;
  fspc_nv_type   nv_store_o;
  logic [17:0]   last_pgm;
  int            pe_n = 0;
  int            errors = 0;
  int            n_compared = 0;
  logic [6:0]    pct [4] = '{7'h50, 7'h28, 7'h64, 7'h3C};
  fspc_row_type  rows [38] = '{
    '{32'h0600_0000, 8, 0, 1, 24'h00_0200, 24'h00_0200, 0},
    '{32'h0400_0000, 8, 0, 1, 24'h00_0200, 24'h00_0000, 0},
    '{32'h011C_0000, 16, 0, 1, 24'h00_7C00, 24'h00_0000, 0},
    '{32'h0600_0000, 8, 0, 1, 24'h00_0000, 24'h00_0000, 0},
    '{32'h011C_0000, 16, 0, 1, 24'h00_7C00, 24'h00_1C00, 0},
    '{32'h0600_0000, 8, 0, 1, 24'h00_0000, 24'h00_0000, 0},
    '{32'h0100_0000, 15, 0, 1, 24'h00_7C00, 24'h00_1C00, 0},
    '{32'h0600_0000, 8, 0, 1, 24'h00_0000, 24'h00_0000, 0},
    '{32'h0100_0000, 16, 0, 1, 24'h00_7C00, 24'h00_0000, 0},
    '{32'h0600_0000, 8, 0, 1, 24'h00_0000, 24'h00_0000, 0},
    '{32'h3108_0000, 16, 0, 1, 24'h38_0000, 24'h08_0000, 0},
    '{32'h0600_0000, 8, 0, 1, 24'h00_0000, 24'h00_0000, 0},
    '{32'h3100_0000, 16, 0, 1, 24'h38_0000, 24'h08_0000, 0},
    '{32'h7500_0000, 8, 2, 1, 24'h80_0000, 24'h80_0000, 0},
    '{32'h7A00_0000, 8, 0, 1, 24'h80_0000, 24'h00_0000, 0},
    '{32'hB000_0000, 8, 1, 1, 24'h04_0000, 24'h04_0000, 0},
    '{32'h6600_0000, 8, 0, 1, 24'h00_0000, 24'h00_0000, 0},
    '{32'h9900_0000, 8, 0, 1, 24'h04_0000, 24'h00_0000, 0},
    '{32'h0600_0000, 8, 0, 1, 24'h00_0000, 24'h00_0000, 0},
    '{32'h11FF_0000, 16, 0, 1, 24'h00_00FF, 24'h00_0071, 0},
    '{32'h0600_0000, 8, 0, 1, 24'h00_0000, 24'h00_0000, 0},
    '{32'h0180_0000, 16, 0, 1, 24'h01_8000, 24'h00_8000, 0},
    '{32'h0600_0000, 8, 0, 0, 24'h00_0000, 24'h00_0000, 0},
    '{32'h019C_0000, 16, 0, 0, 24'h01_FC00, 24'h00_8000, 0},
    '{32'h0600_0000, 8, 0, 0, 24'h00_0000, 24'h00_0000, 0},
    // write-protect and pause pins are driven, never tied
    '{32'h3102_0000, 16, 0, 0, 24'h02_0000, 24'h02_0000, 0},
    '{32'h0600_0000, 8, 0, 0, 24'h00_0000, 24'h00_0000, 0},
    '{32'h019C_0000, 16, 0, 0, 24'h00_7C00, 24'h00_1C00, 0},
    '{32'h0600_0000, 8, 0, 0, 24'h00_0000, 24'h00_0000, 0},
    '{32'h2000_1000, 32, 0, 0, 24'h00_0000, 24'h00_0000, 0},
    '{32'h0600_0000, 8, 0, 0, 24'h00_0000, 24'h00_0000, 0},
    '{32'h0100_0000, 16, 0, 0, 24'h01_FC00, 24'h00_0000, 0},
    '{32'h0600_0000, 8, 0, 0, 24'h00_0000, 24'h00_0000, 0},
    '{32'h2000_1000, 32, 0, 0, 24'h00_0000, 24'h00_0000, 1},
    '{32'hAB00_0000, 8, 0, 0, 24'h00_0000, 24'h00_0000, 1},
    '{32'h0600_0000, 8, 0, 0, 24'h00_0200, 24'h00_0000, 1},
    '{32'hB900_0000, 8, 0, 0, 24'h00_0000, 24'h00_0000, 1},
    '{32'h0600_0000, 8, 0, 0, 24'h00_0200, 24'h00_0200, 1}
  };

  fspc_host_model i_fspc_host_model (
    .clock_i (clock_i),
    .sclk_o  (sclk),
    .cs_n_o  (cs_n),
    .si_o    (si)
  );
  fspc_top i_fspc_top (
    .clock_i              (clock_i),
    .reset_n_i            (reset_n_i),
    .spi_sclk_i           (sclk),
    .spi_cs_n_i           (cs_n),
    .io0_i                (si),
    .wp_n_io2_i           (wp_n),
    .hold_n_io3_i         (hold_n),
    .erase_busy_i         (erase_busy),
    .program_busy_i       (program_busy),
    .nv_load_i            (nv),
    .so_o                 (so),
    .so_oe_o              (so_oe),
    .status_word_o        (status_word_o),
    .configuration_word_o (configuration_word_o),
    .pe_req_o             (pe_req_o),
    .pe_cmd_o             (pe_cmd_o),
    .pgm_valid_o          (pgm_valid_o),
    .pgm_byte_o           (pgm_byte_o),
    .view_o               (view_o),
    .nv_store_o           (nv_store_o)
  );

  initial begin
    clock_i = 1'b0;
    forever #20 clock_i = ~clock_i;
  end
  always @(posedge clock_i) begin
    if (pe_req_o === 1'b1) pe_n <= pe_n + 1;
    if (pgm_valid_o === 1'b1) last_pgm <= pgm_byte_o;
  end
  // the host samples read data on its own rising clock edge
  always @(posedge sclk) begin
    if (so_oe === 1'b1) rx <= {rx[6:0], so};
  end
  assign regs = {status_word_o, configuration_word_o};

  task automatic check(input string what, input logic [23:0] exp,
                       input logic [23:0] got);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wframe(input logic [63:0] d, input int n);
    i_fspc_host_model.frame(64'h0600_0000_0000_0000, 8);
    i_fspc_host_model.frame(d, n);
  endtask
  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // the longest run is far below this bound; reaching it means a hang
  initial begin
    repeat (100000) @(posedge clock_i);
    errors++;
    test_done();
  end

  initial begin
    reset_n_i    = 1'b0;
    erase_busy   = 1'b0;
    program_busy = 1'b0;
    wp_n         = 1'b1;
    last_pgm     = 18'h3_FFFF;
    hold_n       = 1'b1;
    nv           = '0;
    nv.srp       = 2'b10;
    nv.drv       = 2'b11;
    repeat (10) @(posedge clock_i);
    reset_n_i <= 1'b1;
    repeat (4) @(posedge clock_i);
    check("boot", 24'h00_0060, regs);
    hold_n <= 1'b0;
    repeat (4) @(posedge clock_i);
    check("pins_spi", 24'h00_0003,
          24'({view_o.quad_mode, view_o.wp_active, view_o.pause_active}));
    hold_n <= 1'b1;
    repeat (4) @(posedge clock_i);
    $display("test boot done");
    foreach (rows[k]) begin
      erase_busy   <= rows[k].busy[1];
      program_busy <= rows[k].busy[0];
      wp_n         <= rows[k].wp;
      i_fspc_host_model.frame({rows[k].d, 32'h0000_0000}, rows[k].n);
      check($sformatf("row %0d", k), rows[k].exp, // (and row tag)
            regs & rows[k].mask);
      check("pe_count", 24'(rows[k].pe), 24'(pe_n));
    end
    hold_n <= 1'b0;
    repeat (4) @(posedge clock_i);
    check("pins_quad", 24'h00_0004,
          24'({view_o.quad_mode, view_o.wp_active, view_o.pause_active}));
    hold_n <= 1'b1;
    $display("test rows done");
    wframe(64'h0200_00FE_AABB_CC00, 56);
    check("wide_wrap", 24'h03_3100, 24'(last_pgm));
    wframe(64'h8100_0500_0000_0000, 32);
    check("page_erase", 24'h00_0400, pe_cmd_o.addr);
    check("page_op", 24'h00_0103,
          24'({pe_cmd_o.op, pe_cmd_o.wide}));
    for (int i = 0; i < 4; i++) begin
      wframe({8'h11, 1'b0, 2'(i), 4'h0, i[0], 48'h0}, 16);
      check("drive", 24'(pct[i]), 24'(view_o.drive_pct));
      check("dual", i[0] ? 24'h00_0008 : 24'h00_0004,
            24'(view_o.dual_dummy));
      check("quad", i[0] ? 24'h00_000A : 24'h00_0006,
            24'(view_o.quad_dummy));
    end
    wframe(64'h0200_00FE_AABB_CC00, 56);
    check("narrow_wrap", 24'h03_3000, 24'(last_pgm));
    // locks 001 and quad enable set, nothing else in the upper byte
    i_fspc_host_model.frame(64'h3500_0000_0000_0000, 16);
    check("read_hi", 24'h00_000A, 24'(rx));
    i_fspc_host_model.frame(64'h1500_0000_0000_0000, 16);
    check("read_cfg", 24'h00_0061, 24'(rx));
    check("so_oe_idle", 24'h00_0000, 24'(so_oe));
    $display("test page and config done");
    erase_busy <= 1'b1;
    i_fspc_host_model.frame(64'h7500_0000_0000_0000, 8);
    erase_busy <= 1'b0;
    nv         <= nv_store_o;
    @(posedge clock_i);
    reset_n_i <= 1'b0;
    repeat (2) @(posedge clock_i);
    reset_n_i <= 1'b1;
    repeat (4) @(posedge clock_i);
    check("power_cycle", 24'h08_0000, regs & 24'hBC_0200);
    $display("test power cycle done");
    test_done();
  end
endmodule
